/* verilog/pevr_defs.vh */
/*
 power event flags and general control register constants.
 assumes inclusion by bare name from the pevr design file.
*/
`ifndef PEVR_DEFS_VH
`define PEVR_DEFS_VH
`define PEVR_ADDR_W           8
`define PEVR_OFF_POWER_EVENT  8'h18
`define PEVR_OFF_GEN_CTRL     8'h1c
`define PEVR_OFF_INT_STATUS   8'h20
`define PEVR_OFF_INT_MASK     8'h24
`define PEVR_LANE_HI          31
`define PEVR_LANE_LO          24
`define PEVR_STRB_HI          3
`define PEVR_STRB_LO          0
`define PEVR_BIT_LINK_CHG     7
`define PEVR_BIT_WAKE_FRAME   6
`define PEVR_BIT_PKT_MATCH    5
`define PEVR_BIT_MGMT_READY   3
`define PEVR_BIT_MGMT_FORCE   2
`define PEVR_BIT_MGMT_BUSY    1
`define PEVR_BIT_WAKE_STATUS  0
`define PEVR_BIT_DEEP_PD      1
`define PEVR_BIT_CLKRUN_DIS   0
`define PEVR_IRQ_W            4
`define PEVR_IRQ_LINK         0
`define PEVR_IRQ_WAKE_FRAME   1
`define PEVR_IRQ_PKT_MATCH    2
`define PEVR_IRQ_WAKE         3
`define PEVR_ZERO8            8'h00
`define PEVR_ZERO32           32'h00000000
`define PEVR_ZERO4            4'h0
`endif

/* verilog/pevr_regs.v */
/*
 power event flags and general control registers on an apb slave,
 with sticky interrupt status and mask.
 every event bit is one set-wins sticky flag of a small helper module.
 assumes one 250 mhz clock, synchronous inputs, aux_rst_n and rst_n
 both synchronous active low.
*/
// Function
// - an 8-bit power event register sits in bits 31:24 of the word at 18h.
// - bit 31 latches on link status change and clears on a written one.
// - bit 30 sets on any remote-wake frame regardless of enables and clears on a written one.
// - bit 29 sets on a packet filter match and clears on a written one.
// - bit 27 is software read/write and drives the manageability ready output.
// - bit 24 mirrors the wake event status and sets on any wake event.
// - in clearable variants a written one on bit 24 clears it, the mirror and the wake pin; zero does nothing.
// - the power event register's stored bits are zeroed only by the auxiliary reset; bits 26:25 follow mgmt_force_in and mgmt_busy_in.
// - an 8-bit general control register at 1ch has bits 7:2 reading zero and resets on bus reset.
// - control bit 1 with link down in d2 or d3 permits deep power down.
// - control bit 0 keeps the bus clock requested at all times.
`timescale 1ns/10ps
`include "pevr_defs.vh"
module pevr_regs #(
  parameter WAKE_CLEARABLE = 1
) (
  clk,
  rst_n,
  aux_rst_n,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  pstrb,
  prdata,
  pready,
  pslverr,
  link_up,
  wake_frame_rx,
  pkt_match_rx,
  wake_event,
  mgmt_force_in,
  mgmt_busy_in,
  power_state_low,
  manageability_ready,
  wake_status_out,
  wake_n,
  deep_power_down,
  clk_req_force,
  irq
);
  input  wire        clk;
  input  wire        rst_n;
  input  wire        aux_rst_n;
  input  wire        psel;
  input  wire        penable;
  input  wire        pwrite;
  input  wire [7:0]  paddr;
  input  wire [31:0] pwdata;
  input  wire [3:0]  pstrb;
  output reg  [31:0] prdata;
  output reg         pready;
  output reg         pslverr;
  input  wire        link_up;
  input  wire        wake_frame_rx;
  input  wire        pkt_match_rx;
  input  wire        wake_event;
  input  wire        mgmt_force_in;
  input  wire        mgmt_busy_in;
  input  wire        power_state_low;
  output reg         manageability_ready;
  output reg         wake_status_out;
  output reg         wake_n;
  output reg         deep_power_down;
  output reg         clk_req_force;
  output reg         irq;

  wire        link_chg_reg;
  wire        wake_frame_reg;
  wire        pkt_match_reg;
  reg         mgmt_ready_reg;
  wire        wake_status_reg;
  reg         link_prev_reg;
  reg         link_seen_reg;
  reg  [1:0]  gen_ctrl_reg;
  wire [3:0]  int_status_reg;
  reg  [3:0]  int_mask_reg;
  reg  [31:0] rdata_next;
  reg         err_next;

  wire        link_chg_clr;
  wire        wake_frame_clr;
  wire        pkt_match_clr;
  wire        wake_status_clr;
  wire [3:0]  int_status_clr;

  // apb decode; writes land on the completing edge
  wire access     = psel && penable && !pready;
  wire xfer_end   = psel && penable && pready;
  wire wr         = xfer_end && pwrite;
  wire wr_hi      = wr && pstrb[`PEVR_STRB_HI];
  wire wr_lo      = wr && pstrb[`PEVR_STRB_LO];
  wire hit_pe     = (paddr == `PEVR_OFF_POWER_EVENT);
  wire hit_gc     = (paddr == `PEVR_OFF_GEN_CTRL);
  wire hit_is     = (paddr == `PEVR_OFF_INT_STATUS);
  wire hit_im     = (paddr == `PEVR_OFF_INT_MASK);
  wire [7:0] pe_wb = pwdata[`PEVR_LANE_HI:`PEVR_LANE_LO];
  wire link_chg   = link_seen_reg && (link_up != link_prev_reg);
  wire pe_w1c     = wr_hi && hit_pe;
  wire is_w1c     = wr_lo && hit_is;
  wire [3:0] ev   = {wake_event, pkt_match_rx, wake_frame_rx, link_chg};
  wire [7:0] pe_value = {link_chg_reg, wake_frame_reg, pkt_match_reg, 1'b0,
                         mgmt_ready_reg, mgmt_force_in, mgmt_busy_in, wake_status_reg};

  // write-one-to-clear strobes
  assign link_chg_clr    = pe_w1c && pe_wb[`PEVR_BIT_LINK_CHG];
  assign wake_frame_clr  = pe_w1c && pe_wb[`PEVR_BIT_WAKE_FRAME];
  assign pkt_match_clr   = pe_w1c && pe_wb[`PEVR_BIT_PKT_MATCH];
  assign wake_status_clr = (WAKE_CLEARABLE != 0) && pe_w1c && pe_wb[`PEVR_BIT_WAKE_STATUS];
  assign int_status_clr  = is_w1c ? pwdata[`PEVR_IRQ_W-1:0] : `PEVR_ZERO4;

  // manageability ready and link edge tracking, aux reset domain
  always @(posedge clk) begin
    if (!aux_rst_n) begin
      mgmt_ready_reg <= 1'b0;
      link_prev_reg  <= 1'b0;
      link_seen_reg  <= 1'b0;
    end else begin
      link_prev_reg <= link_up;
      link_seen_reg <= 1'b1;
      if (pe_w1c) begin
        mgmt_ready_reg <= pe_wb[`PEVR_BIT_MGMT_READY];
      end
    end
  end

  // power event flags, reset only by the aux reset
  // bit 31, link status change
  pevr_sticky link_chg_u (
    .clk   (clk),
    .rst_n (aux_rst_n),
    .set   (link_chg),
    .clr   (link_chg_clr),
    .flag  (link_chg_reg)
  );

  // bit 30, remote-wake frame
  pevr_sticky wake_frame_u (
    .clk   (clk),
    .rst_n (aux_rst_n),
    .set   (wake_frame_rx),
    .clr   (wake_frame_clr),
    .flag  (wake_frame_reg)
  );

  // bit 29, packet filter match
  pevr_sticky pkt_match_u (
    .clk   (clk),
    .rst_n (aux_rst_n),
    .set   (pkt_match_rx),
    .clr   (pkt_match_clr),
    .flag  (pkt_match_reg)
  );

  // bit 24, wake event status
  pevr_sticky wake_status_u (
    .clk   (clk),
    .rst_n (aux_rst_n),
    .set   (wake_event),
    .clr   (wake_status_clr),
    .flag  (wake_status_reg)
  );

  // interrupt status, cleared by bus reset
  // link change
  pevr_sticky irq_link_u (
    .clk   (clk),
    .rst_n (rst_n),
    .set   (ev[`PEVR_IRQ_LINK]),
    .clr   (int_status_clr[`PEVR_IRQ_LINK]),
    .flag  (int_status_reg[`PEVR_IRQ_LINK])
  );

  // remote-wake frame
  pevr_sticky irq_wake_frame_u (
    .clk   (clk),
    .rst_n (rst_n),
    .set   (ev[`PEVR_IRQ_WAKE_FRAME]),
    .clr   (int_status_clr[`PEVR_IRQ_WAKE_FRAME]),
    .flag  (int_status_reg[`PEVR_IRQ_WAKE_FRAME])
  );

  // packet filter match
  pevr_sticky irq_pkt_match_u (
    .clk   (clk),
    .rst_n (rst_n),
    .set   (ev[`PEVR_IRQ_PKT_MATCH]),
    .clr   (int_status_clr[`PEVR_IRQ_PKT_MATCH]),
    .flag  (int_status_reg[`PEVR_IRQ_PKT_MATCH])
  );

  // wake event
  pevr_sticky irq_wake_u (
    .clk   (clk),
    .rst_n (rst_n),
    .set   (ev[`PEVR_IRQ_WAKE]),
    .clr   (int_status_clr[`PEVR_IRQ_WAKE]),
    .flag  (int_status_reg[`PEVR_IRQ_WAKE])
  );

  // bus reset domain: control, interrupts, bus
  always @(posedge clk) begin
    if (!rst_n) begin
      gen_ctrl_reg   <= 2'b00;
      int_mask_reg   <= `PEVR_ZERO4;
      prdata         <= `PEVR_ZERO32;
      pready         <= 1'b0;
      pslverr        <= 1'b0;
      irq            <= 1'b0;
    end else begin
      if (wr_lo && hit_gc) begin
        gen_ctrl_reg <= pwdata[1:0];
      end
      if (wr_lo && hit_im) begin
        int_mask_reg <= pwdata[3:0];
      end
      irq    <= |(int_status_reg & int_mask_reg);
      pready <= access;
      if (access) begin
        prdata  <= rdata_next;
        pslverr <= err_next;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // read mux and address decode
  always @* begin
    rdata_next = `PEVR_ZERO32;
    err_next   = 1'b0;
    if (hit_pe) begin
      rdata_next[`PEVR_LANE_HI:`PEVR_LANE_LO] = pe_value;
    end else if (hit_gc) begin
      rdata_next[1:0] = gen_ctrl_reg;
    end else if (hit_is) begin
      rdata_next[3:0] = int_status_reg;
    end else if (hit_im) begin
      rdata_next[3:0] = int_mask_reg;
    end else begin
      err_next = 1'b1;
    end
  end

  // pin outputs registered
  always @(posedge clk) begin
    if (!rst_n) begin
      deep_power_down <= 1'b0;
      clk_req_force   <= 1'b0;
    end else begin
      deep_power_down <= gen_ctrl_reg[`PEVR_BIT_DEEP_PD] && !link_up && power_state_low;
      clk_req_force   <= gen_ctrl_reg[`PEVR_BIT_CLKRUN_DIS];
    end
  end

  always @(posedge clk) begin
    if (!aux_rst_n) begin
      manageability_ready <= 1'b0;
      wake_status_out     <= 1'b0;
      wake_n              <= 1'b1;
    end else begin
      manageability_ready <= mgmt_ready_reg;
      wake_status_out     <= wake_status_reg;
      wake_n              <= !wake_status_reg;
    end
  end
endmodule

module pevr_sticky (
  clk,
  rst_n,
  set,
  clr,
  flag
);
  input  wire clk;
  input  wire rst_n;
  input  wire set;
  input  wire clr;
  output reg  flag;

  // set wins over a same-cycle clear
  always @(posedge clk) begin
    if (!rst_n) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clr) begin
      flag <= 1'b0;
    end
  end
endmodule

/* dv/pevr_regs_asserts.sv */
/* port checker for pevr_regs.
 assumes bind onto pevr_regs, one clock. */
`timescale 1ns/10ps
module pevr_chk (
  input wire logic        clk, rst_n, aux_rst_n, psel, penable, pready, pslverr, link_up, wake_event,
  input wire logic        power_state_low, manageability_ready, wake_status_out, wake_n, deep_power_down, irq,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_one_wait: assert property (psel && penable && !pready |=> pready) else $error("no answer");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_unmapped_err: assert property (psel && penable && !pready && !(paddr inside {8'h18, 8'h1c, 8'h20, 8'h24})
    |=> pslverr && prdata == 32'h00000000) else $error("unmapped accepted");
  a_wake_sets: assert property (disable iff (!aux_rst_n) wake_event |-> ##[1:2] wake_status_out)
    else $error("wake lost");
  a_wake_pin_inv: assert property (disable iff (!aux_rst_n) wake_n == !wake_status_out) else $error("pin");
  a_bus_rst_keeps: assert property (disable iff (!aux_rst_n) !rst_n && wake_status_out |=> wake_status_out)
    else $error("bus reset cleared");
  a_aux_clears: assert property (!aux_rst_n |=> !manageability_ready && wake_n) else $error("aux");
  a_deep_pd_cond: assert property (deep_power_down |-> $past(power_state_low) && !$past(link_up))
    else $error("deep power down");
  cover property (pslverr);
  cover property (deep_power_down);
  cover property (irq);
endmodule
bind pevr_regs pevr_chk u_chk (.clk, .rst_n, .aux_rst_n, .psel, .penable, .pready, .pslverr, .link_up,
  .wake_event, .power_state_low, .manageability_ready, .wake_status_out, .wake_n, .deep_power_down, .irq,
  .paddr, .prdata);

/* dv/pevr_far.sv */
/* event source model: link and receive events.
 assumes go held by the bench for as long as an event should last. */
`timescale 1ns/10ps
module pevr_far (
  input  wire logic       clk,
  input  wire logic [3:0] go,
  output logic            link_up = 1'b0,
  output logic            wake_frame_rx = 1'b0,
  output logic            pkt_match_rx = 1'b0,
  output logic            wake_event = 1'b0
);
  always @(posedge clk) begin
    link_up <= link_up ^ go[0];
    wake_frame_rx <= go[1];
    pkt_match_rx <= go[2];
    wake_event <= go[3];
  end
endmodule

/* dv/test_power_event_and_general_control_regs.sv */
/* bench for pevr_regs over apb.
 assumes pevr_far as event source. */
`timescale 1ns/10ps
module test_power_event_and_general_control_regs;
  logic        clk = 0, rst_n = 0, aux_rst_n = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic        mgmt_force_in = 0, mgmt_busy_in = 0, power_state_low = 0, pready, pslverr;
  logic        link_up, wake_frame_rx, pkt_match_rx, wake_event, manageability_ready;
  logic        wake_status_out, wake_n, deep_power_down, clk_req_force, irq;
  logic [7:0]  paddr = 8'h00;
  logic [3:0]  go = 4'h0, pstrb = 4'hf;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  int          n_fail = 0, cmp_count = 0;
  always #2 clk = ~clk;
  pevr_regs dut_u (.clk, .rst_n, .aux_rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .link_up, .wake_frame_rx, .pkt_match_rx, .wake_event, .mgmt_force_in, .mgmt_busy_in,
    .power_state_low, .manageability_ready, .wake_status_out, .wake_n, .deep_power_down, .clk_req_force, .irq);
  pevr_far far_u (.clk, .go, .link_up, .wake_frame_rx, .pkt_match_rx, .wake_event);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic kick(input logic [3:0] g);
    @(posedge clk);
    go <= g;
    @(posedge clk);
    go <= 4'h0;
  endtask
  task automatic t_events;
    apb(1, 8'h24, 32'h0000000f);
    kick(4'hf);
    apb(0, 8'h18, 0);
    chk(rd, 32'he1000000);
    chk(wake_n, 0);
    chk(wake_status_out, 1);
    chk(irq, 1);
    apb(1, 8'h18, 32'he1000000);
    apb(1, 8'h20, 32'h0000000f);
    apb(0, 8'h18, 0);
    chk(rd, 0);
    chk(wake_n, 1);
    chk(wake_status_out, 0);
    chk(irq, 0);
  endtask
  task automatic t_mgmt;
    mgmt_busy_in <= 1'b1;
    mgmt_force_in <= 1'b1;
    apb(1, 8'h18, 32'h08000000);
    apb(0, 8'h18, 0);
    chk(rd, 32'h0e000000);
    chk(manageability_ready, 1);
    apb(1, 8'h18, 0);
    repeat (2) @(posedge clk);
    chk(manageability_ready, 0);
  endtask
  task automatic t_race;
    go <= 4'h2;
    apb(1, 8'h18, 32'h40000000);
    apb(1, 8'h20, 32'h00000002);
    go <= 4'h0;
    apb(0, 8'h18, 0);
    chk(rd, 32'h46000000);
    apb(0, 8'h20, 0);
    chk(rd, 32'h00000002);
    pstrb <= 4'h7;
    apb(1, 8'h18, 32'h40000000);
    pstrb <= 4'hf;
    apb(0, 8'h18, 0);
    chk(rd, 32'h46000000);
    apb(1, 8'h18, 32'h40000000);
    apb(1, 8'h20, 32'h00000002);
    apb(0, 8'h18, 0);
    chk(rd, 32'h06000000);
  endtask
  task automatic t_gen;
    power_state_low <= 1'b1;
    apb(1, 8'h1c, 32'h000000ff);
    apb(0, 8'h1c, 0);
    chk(rd, 32'h00000003);
    chk(clk_req_force, 1);
    kick(4'h1);
    repeat (2) @(posedge clk);
    chk(deep_power_down, 1);
    apb(0, 8'h40, 0);
    chk(rd, 0);
    chk(err, 1);
  endtask
  task automatic t_resets;
    kick(4'h8);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    chk(wake_n, 0);
    apb(0, 8'h1c, 0);
    chk(rd, 0);
    aux_rst_n <= 1'b0;
    @(posedge clk);
    aux_rst_n <= 1'b1;
    @(posedge clk);
    chk(wake_n, 1);
  endtask
  task automatic give_verdict;
    if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    aux_rst_n <= 1'b1;
    t_events;
    t_mgmt;
    t_race;
    t_gen;
    t_resets;
    give_verdict;
  end
  initial begin
    #20000;
    n_fail++;
    give_verdict;
  end
endmodule
